// >>> channel_memory_fifo.sv
// Channel memory block configured as a synchronous FIFO with a Wishbone register port
// How it works
// - Pointers and all flags live inside the block, no fabric logic needed.
// - Outputs empty/full, half-full and programmable almost-empty/full flags.
// - A write and a read may both happen in one period, each on its clock.
// - Port clocks may share a source or run unrelated; both work.
// - Each port picks one of six clock sources: four global, two local.
// - Read data passes straight or through an extra output register.
// - Each port chooses true or inverted clock, acting on either edge.
// - Apart from preload, a word is written only on an active write edge with write enable high.
// - A word is read only on an active read edge with read enable high.
// - Array contents are undefined after power-up until loaded.
// - A data image may be preloaded into the array.
// - In lookup or ROM use, all user writes are blocked.
// - Data and flags drive dedicated outputs so blocks cascade freely.
// - The array holds 4096 bits.
// - Organisations 4Kx1, 2Kx2, 1Kx4, 512x8; depth halves as width doubles.
`include "channel_memory_fifo_map.svh"
`timescale 1ns/1ps
`default_nettype none

module channel_memory_fifo (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output var  logic [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output var  logic        ack_o,
    output logic             irq_o,
    input  wire logic [5:0]  clk_src_i,
    input  wire logic        wr_en_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        rd_en_i,
    output logic      [7:0]  rd_data_o,
    output logic             empty_full_flag_o,
    output logic             half_full_flag_o,
    output logic             prog_almost_empty_full_flag_o
);

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    logic [15:0] pin_s1_q;
    logic [15:0] pin_s2_q;
    logic [5:0]  clk_s3_q;
    logic [11:0] ctrl_q;
    logic [12:0] almost_q;
    logic        wr_edge;
    logic        rd_edge;

    // Two flops on every fabric pin; a third flop on the clock pins holds the previous level for edge detection
    always_ff @(posedge clk_i) begin
        pin_s1_q <= {clk_src_i, rd_en_i, wr_en_i, wr_data_i};
        pin_s2_q <= pin_s1_q;
        clk_s3_q <= pin_s2_q[15:10];
    end

    // Picks a source and detects its active edge; codes 6 and 7 never fire
    function automatic logic port_edge(input logic [5:0] cur, input logic [5:0] prev,
                                       input logic [2:0] sel, input logic inv);
        logic c;
        logic p;
        c = 1'b0;
        p = 1'b0;
        if (sel < `CLK_SRCS) begin
            c = cur[sel];
            p = prev[sel];
        end
        port_edge = inv ? (p & ~c) : (~p & c);
    endfunction

    // Sampling, not clocking, keeps one domain whether sources are related or not
    assign wr_edge = port_edge(pin_s2_q[15:10], clk_s3_q,
                               ctrl_q[`CTRL_WSEL_LSB +: 3], ctrl_q[`CTRL_WINV_BIT]);
    assign rd_edge = port_edge(pin_s2_q[15:10], clk_s3_q,
                               ctrl_q[`CTRL_RSEL_LSB +: 3], ctrl_q[`CTRL_RINV_BIT]);

    // ****************************************
    // Queue control
    // ****************************************
    channel_memory_fifo_pkg::org_type org;
    logic [12:0] depth;
    logic [12:0] count_q;
    logic [11:0] wr_ptr_q;
    logic [11:0] rd_ptr_q;
    logic        rom;
    logic        full;
    logic        empty;
    logic        push_req;
    logic        pop_req;
    logic        push_ok;
    logic        pop_ok;
    logic        preload_wr;
    logic        ctrl_wr;
    logic        flush;
    logic        bus_req;
    logic [7:0]  wr_word;

    assign org   = channel_memory_fifo_pkg::org_type'(ctrl_q[`CTRL_ORG_LSB +: 2]);
    assign depth = `WORDS_MAX >> org;
    assign rom   = ctrl_q[`CTRL_ROM_BIT];
    assign full  = (count_q == depth);
    assign empty = (count_q == 13'h0000);

    // Each port acts only on its own edge with its own enable
    assign push_req = wr_edge & pin_s2_q[8];
    assign pop_req  = rd_edge & pin_s2_q[9];

    // Preload takes the write path even in ROM use; user writes do not
    assign push_ok = (preload_wr | (push_req & ~rom)) & ~full;
    assign pop_ok  = pop_req & ~empty;
    assign wr_word = preload_wr ? dat_i[7:0] : pin_s2_q[7:0];

    // Changing the organisation flushes the queue; old pointers mean nothing
    assign flush = ctrl_wr && (dat_i[`CTRL_ORG_LSB +: 2] != ctrl_q[`CTRL_ORG_LSB +: 2]);

    // Wrap a word pointer at the configured depth
    function automatic logic [11:0] ptr_next(input logic [11:0] p, input logic [12:0] d);
        logic [12:0] last;
        last = d - 13'h0001;
        ptr_next = (p == last[11:0]) ? 12'h000 : p + 12'h001;
    endfunction

    // Pointers and fill level held inside the block
    always_ff @(posedge clk_i) begin
        if (rst_i || flush) begin
            wr_ptr_q <= 12'h000;
            rd_ptr_q <= 12'h000;
            count_q  <= 13'h0000;
        end else begin
            if (push_ok) begin
                wr_ptr_q <= ptr_next(wr_ptr_q, depth);
            end
            if (pop_ok) begin
                rd_ptr_q <= ptr_next(rd_ptr_q, depth);
            end
            count_q <= count_q + {12'h000, push_ok} - {12'h000, pop_ok};
        end
    end

    // ****************************************
    // Storage array
    // ****************************************
    logic        mem_q [0:`MEM_BITS-1];
    logic [11:0] wr_base;
    logic [11:0] rd_base;
    logic [7:0]  rd_word;
    logic [7:0]  rd_pass_q;
    logic [7:0]  rd_pipe_q;

    // Bit address is word pointer times width
    assign wr_base = wr_ptr_q << org;
    assign rd_base = rd_ptr_q << org;

    // No reset on the array: contents stay undefined until loaded
    always_ff @(posedge clk_i) begin
        if (push_ok) begin
            for (int k = 0; k < 8; k++) begin
                if (k < (32'd1 << org)) begin
                    mem_q[wr_base + 12'(k)] <= wr_word[k];
                end
            end
        end
    end

    // Gather the word at the read pointer; unused upper bits read zero
    always_comb begin
        rd_word = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (k < (32'd1 << org)) begin
                rd_word[k] = mem_q[rd_base + 12'(k)];
            end
        end
    end

    // Read data capture, optional extra stage for timing at the cost of latency
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_pass_q <= 8'h00;
            rd_pipe_q <= 8'h00;
        end else begin
            if (pop_ok) begin
                rd_pass_q <= rd_word;
            end
            rd_pipe_q <= rd_pass_q;
        end
    end

    // ****************************************
    // Dedicated data and flag outputs
    // ****************************************
    assign rd_data_o = ctrl_q[`CTRL_OUTREG_BIT] ? rd_pipe_q : rd_pass_q;
    assign empty_full_flag_o = empty | full;
    assign half_full_flag_o  = (count_q >= (depth >> 1));
    assign prog_almost_empty_full_flag_o = (count_q <= almost_q) ||
                                           (count_q >= (depth - almost_q));

    // ****************************************
    // Interrupts
    // ****************************************
    logic [3:0] int_stat_q;
    logic [3:0] int_en_q;
    logic [3:0] events;
    logic [3:0] clr;
    logic       half_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            half_q <= 1'b0;
        end else begin
            half_q <= half_full_flag_o;
        end
    end

    assign events[`EV_WR_FULL]  = push_req & ~rom & full;
    assign events[`EV_RD_EMPTY] = pop_req & empty;
    assign events[`EV_ROM_WR]   = push_req & rom;
    assign events[`EV_HALF]     = half_full_flag_o & ~half_q;
    assign clr = (bus_req && we_i && adr_i == `INT_CLR_OFS && sel_i[0]) ? dat_i[3:0] : 4'h0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_stat_q <= 4'h0;
        end else begin
            int_stat_q <= (int_stat_q & ~clr) | events;
        end
    end

    assign irq_o = |(int_stat_q & int_en_q);

    // ****************************************
    // Wishbone slave
    // ****************************************
    assign bus_req    = cyc_i & stb_i & ~ack_o;
    assign ctrl_wr    = bus_req && we_i && adr_i == `CTRL_OFS;
    assign preload_wr = bus_req && we_i && adr_i == `PRELOAD_OFS && sel_i[0];

    // Byte-lane masked update of a register word
    function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            lanes[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    // Writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q   <= `CTRL_RST;
            almost_q <= `ALMOST_RST;
            int_en_q <= 4'h0;
        end else if (bus_req && we_i) begin
            unique case (adr_i)
                `CTRL_OFS:   ctrl_q   <= 12'(lanes({20'h0, ctrl_q}, dat_i, sel_i));
                `ALMOST_OFS: almost_q <= 13'(lanes({19'h0, almost_q}, dat_i, sel_i));
                `INT_EN_OFS: int_en_q <= 4'(lanes({28'h0, int_en_q}, dat_i, sel_i));
                default: ;
            endcase
        end
    end

    // One wait state: ack the cycle after the request, drop it the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            if (bus_req && !we_i) begin
                unique case (adr_i)
                    `CTRL_OFS:     dat_o <= {20'h0, ctrl_q};
                    `ALMOST_OFS:   dat_o <= {19'h0, almost_q};
                    `FLAGS_OFS:    dat_o <= {27'h0, full, empty, prog_almost_empty_full_flag_o,
                                             half_full_flag_o, empty_full_flag_o};
                    `COUNT_OFS:    dat_o <= {19'h0, count_q};
                    `INT_STAT_OFS: dat_o <= {28'h0, int_stat_q};
                    `INT_EN_OFS:   dat_o <= {28'h0, int_en_q};
                    default:       dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_pop_reg;
        pop_ok && ctrl_q[`CTRL_OUTREG_BIT] && !ctrl_wr;
    endsequence

    // Output register left alone the cycle after the read
    sequence s_reg_hold;
        !ctrl_wr;
    endsequence

    a_full_no_push: assert property (full && !pop_ok && !flush |=> count_q == $past(count_q))
        else $error("Count moved on a write while full");
    a_empty_no_pop: assert property (empty && !push_ok && !flush |=> count_q == 13'h0000)
        else $error("Count moved on a read while empty");
    a_half_rise_level: assert property ($rose(half_full_flag_o) |-> count_q == (depth >> 1))
        else $error("Half-full rose at the wrong level");
    a_empty_full_meaning: assert property (empty_full_flag_o
        |-> (count_q == 13'h0000 || count_q == depth) && wr_ptr_q == rd_ptr_q)
        else $error("Empty/full flag set while partly filled");
    a_rom_blocks_write: assert property (rom && !preload_wr && !pop_ok && !flush
        |=> wr_ptr_q == $past(wr_ptr_q))
        else $error("User write reached the array in ROM use");
    a_write_on_edge: assert property (!$past(rst_i) && !$past(flush)
        && wr_ptr_q != $past(wr_ptr_q) |-> $past(push_req || preload_wr))
        else $error("Write pointer moved without a write edge");
    a_read_on_edge: assert property (!$past(rst_i) && !$past(flush)
        && rd_ptr_q != $past(rd_ptr_q) |-> $past(pop_req))
        else $error("Read pointer moved without a read edge");
    a_out_reg_delay: assert property (s_pop_reg ##1 s_reg_hold
        |=> rd_data_o == $past(rd_word, 2))
        else $error("Registered read data not two cycles after the read");
    a_bus_ack_pulse: assert property (bus_req |=> ack_o ##1 !ack_o)
        else $error("Bus ack not a one-cycle pulse after the request");

endmodule // channel_memory_fifo

`default_nettype wire

// >>> channel_memory_fifo_map.svh
// Register offsets, field positions, reset values and sizes of the channel FIFO
`ifndef CHANNEL_MEMORY_FIFO_MAP_SVH
`define CHANNEL_MEMORY_FIFO_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CTRL_OFS      8'h00
`define ALMOST_OFS    8'h04
`define FLAGS_OFS     8'h08
`define COUNT_OFS     8'h0c
`define INT_STAT_OFS  8'h10
`define INT_CLR_OFS   8'h14
`define INT_EN_OFS    8'h18
`define PRELOAD_OFS   8'h1c

// ****************************************
// Control fields and register reset values
// ****************************************
`define CTRL_ORG_LSB     0
`define CTRL_ROM_BIT     2
`define CTRL_OUTREG_BIT  3
`define CTRL_WSEL_LSB    4
`define CTRL_RSEL_LSB    7
`define CTRL_WINV_BIT    10
`define CTRL_RINV_BIT    11
`define CTRL_RST         12'h000
`define ALMOST_RST       13'h0010

// ****************************************
// Interrupt event bits
// ****************************************
`define EV_WR_FULL   0
`define EV_RD_EMPTY  1
`define EV_ROM_WR    2
`define EV_HALF      3

// ****************************************
// Array size and clock source count
// ****************************************
`define MEM_BITS   4096
`define WORDS_MAX  13'h1000
`define CLK_SRCS   3'd6

`endif

// >>> channel_memory_fifo_pkg.sv
// Types shared by the channel FIFO
package channel_memory_fifo_pkg;
    // Depth by width organisations
    typedef enum logic [1:0] {org_4kx1, org_2kx2, org_1kx4, org_512x8} org_type;
endpackage

// >>> fabric_user_model.sv
// Fabric user logic model on the FIFO write and read ports
`timescale 1ns/1ps
`default_nettype none
module fabric_user_model (
    input  wire logic       clk_i,
    output var  logic [5:0] clk_src_o,
    output var  logic       wr_en_o,
    output var  logic [7:0] wr_data_o,
    output var  logic       rd_en_o,
    input  wire logic [7:0] rd_data_i
);
    // Stable pins from time zero, the synchronisers are not reset
    initial begin
        clk_src_o = 6'h00;
        wr_en_o = 1'b0;
        wr_data_o = 8'h00;
        rd_en_o = 1'b0;
    end

    // One full source pulse; enables stay up over the whole pulse
    task automatic xfer(input logic w, input logic r, input logic [7:0] d,
                        input int idx, output logic [7:0] q);
        @(posedge clk_i);
        wr_en_o <= w;
        rd_en_o <= r;
        wr_data_o <= d;
        repeat (3) @(posedge clk_i);
        clk_src_o[idx] <= 1'b1;
        repeat (4) @(posedge clk_i);
        clk_src_o[idx] <= 1'b0;
        repeat (4) @(posedge clk_i);
        q = rd_data_i;
        wr_en_o <= 1'b0;
        rd_en_o <= 1'b0;
        wr_data_o <= ~d; // Idle lane never shows the last word
    endtask

    // One source level change with the write enable, then time to settle
    task automatic hold(input logic w, input int idx, input logic lvl);
        @(posedge clk_i);
        wr_en_o <= w;
        clk_src_o[idx] <= lvl;
        repeat (4) @(posedge clk_i);
    endtask
endmodule // fabric_user_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the channel FIFO
`include "channel_memory_fifo_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        we_i = 1'b0;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        ack_o;
    logic        irq_o;
    logic [5:0]  src;
    logic        wr_en;
    logic [7:0]  wr_data;
    logic        rd_en;
    logic [7:0]  rd_data;
    logic        either_flag;
    logic        half_flag;
    logic        almost_flag;
    logic [31:0] q;
    logic [7:0]  b;
    int          n_mismatch = 0;
    int          checks_done = 0;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    channel_memory_fifo dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(4'hf), .cyc_i(cyc_i), .stb_i(stb_i),
        .ack_o(ack_o), .irq_o(irq_o), .clk_src_i(src), .wr_en_i(wr_en),
        .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_data_o(rd_data),
        .empty_full_flag_o(either_flag), .half_full_flag_o(half_flag),
        .prog_almost_empty_full_flag_o(almost_flag));

    fabric_user_model fab (.clk_i(clk_i), .clk_src_o(src), .wr_en_o(wr_en),
        .wr_data_o(wr_data), .rd_en_o(rd_en), .rd_data_i(rd_data));

    // Verdict and end of run
    task automatic end_of_test();
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Register word compare
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pin compare, flags and read words
    task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
        cmp_reg({24'h0, got}, {24'h0, exp});
    endtask

    // Classic single cycle; waits for ack with no assumed latency
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        cmp_reg(r, exp);
    endtask

    task automatic pop_chk(input logic [7:0] exp);
        logic [7:0] r;
        fab.xfer(1'b0, 1'b1, 8'h00, 0, r);
        cmp_pin(r, exp);
    endtask

    // Hang guard, the whole run needs about 8000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(`CTRL_OFS, 32'h0);
        rd_chk(`ALMOST_OFS, 32'h10);
        rd_chk(`FLAGS_OFS, 32'h0d);
        cmp_pin({5'h0, either_flag, half_flag, almost_flag}, 8'h05);
        wb(1'b1, 8'h20, 32'h3, q);
        rd_chk(8'h20, 32'h0);
        rd_chk(`CTRL_OFS, 32'h0);
        // Narrow organisation keeps only bit 0
        fab.xfer(1'b1, 1'b0, 8'hff, 0, b);
        rd_chk(`COUNT_OFS, 32'h1);
        pop_chk(8'h01);
        // Read while empty, then interrupt masked, enabled and cleared
        fab.xfer(1'b0, 1'b1, 8'h00, 0, b);
        rd_chk(`COUNT_OFS, 32'h0);
        rd_chk(`INT_STAT_OFS, 32'h2);
        cmp_pin({7'h0, irq_o}, 8'h00);
        wb(1'b1, `INT_EN_OFS, 32'h2, q);
        cmp_pin({7'h0, irq_o}, 8'h01);
        wb(1'b1, `INT_CLR_OFS, 32'h2, q);
        cmp_pin({7'h0, irq_o}, 8'h00);
        // Two-bit words and a zero threshold, then four-bit words on inverted edges
        wb(1'b1, `CTRL_OFS, 32'h1, q);
        fab.xfer(1'b1, 1'b0, 8'hfe, 0, b);
        wb(1'b1, `ALMOST_OFS, 32'h0, q);
        rd_chk(`FLAGS_OFS, 32'h00);
        wb(1'b1, `ALMOST_OFS, 32'h10, q);
        pop_chk(8'h02);
        wb(1'b1, `CTRL_OFS, 32'hc02, q);
        fab.hold(1'b1, 0, 1'b1);
        rd_chk(`COUNT_OFS, 32'h0);
        fab.hold(1'b1, 0, 1'b0);
        rd_chk(`COUNT_OFS, 32'h1);
        pop_chk(8'h0f);
        // Every clock source on both ports
        for (int s = 0; s < 6; s++) begin
            wb(1'b1, `CTRL_OFS, 32'(channel_memory_fifo_pkg::org_512x8) | (s << 4) | (s << 7), q);
            fab.xfer(1'b1, 1'b0, 8'ha0 + 8'(s), s, b);
            fab.xfer(1'b0, 1'b1, 8'h00, s, b);
            cmp_pin(b, 8'ha0 + 8'(s));
        end
        // Write and read on one edge
        wb(1'b1, `CTRL_OFS, 32'h3, q);
        fab.xfer(1'b1, 1'b0, 8'h11, 0, b);
        fab.xfer(1'b1, 1'b0, 8'h22, 0, b);
        fab.xfer(1'b1, 1'b1, 8'h33, 0, b);
        cmp_pin(b, 8'h11);
        rd_chk(`COUNT_OFS, 32'h2);
        pop_chk(8'h22);
        pop_chk(8'h33);
        // Lookup use blocks fabric writes but preload still fills
        wb(1'b1, `CTRL_OFS, 32'h7, q);
        fab.xfer(1'b1, 1'b0, 8'h55, 0, b);
        rd_chk(`COUNT_OFS, 32'h0);
        rd_chk(`INT_STAT_OFS, 32'h4);
        wb(1'b1, `INT_CLR_OFS, 32'hf, q);
        for (int i = 0; i < 512; i++) begin
            cmp_pin({5'h0, either_flag, half_flag, almost_flag},
                    {5'h0, i == 0, i >= 256, i <= 16 || i >= 496});
            wb(1'b1, `PRELOAD_OFS, i, q);
        end
        rd_chk(`FLAGS_OFS, 32'h17);
        rd_chk(`COUNT_OFS, 32'h200);
        wb(1'b1, `CTRL_OFS, 32'hb, q);
        fab.xfer(1'b1, 1'b0, 8'h77, 0, b);
        wb(1'b1, `PRELOAD_OFS, 32'hee, q);
        rd_chk(`COUNT_OFS, 32'h200);
        rd_chk(`INT_STAT_OFS, 32'h9);
        // Drain through the output register, order kept
        for (int i = 0; i < 512; i++)
            pop_chk(8'(i));
        rd_chk(`FLAGS_OFS, 32'h0d);
        end_of_test();
    end
endmodule // tb
`default_nettype wire
